// *** core/vdnc_top.v ***
// Purpose: register bank, framing checks and edge-aware smoothing datapath
// Assumes: stream and register bus both on clk_i; one pixel per beat
// Notes: filter is a causal 3-tap horizontal smoother, one cycle latency
`timescale 1ns/100ps
`default_nettype none
`include "vdnc_consts.vh"
module vdnc_top #(
	parameter DATA_W = 8,
	// widest line an instance is meant for; sizes are not clamped to it
	parameter MAX_PIX = 13'd1920,
	parameter [12:0] DEF_PIX = 13'd1920,
	parameter [12:0] DEF_LIN = 13'd1080,
	parameter [2:0] DEF_STR = 3'd2,
	// arbitrary neutral revision value
	parameter [31:0] REV_VALUE = 32'h0100_0000
) (
	// clock and reset
	input wire clk_i,
	input wire rst_n_i,
	// register bus write channels
	input wire [11:0] s_axi_awaddr_i,
	input wire s_axi_awvalid_i,
	output wire s_axi_awready_o,
	input wire [31:0] s_axi_wdata_i,
	input wire [3:0] s_axi_wstrb_i,
	input wire s_axi_wvalid_i,
	output wire s_axi_wready_o,
	output reg [1:0] s_axi_bresp_o,
	output reg s_axi_bvalid_o,
	input wire s_axi_bready_i,
	// register bus read channels
	input wire [11:0] s_axi_araddr_i,
	input wire s_axi_arvalid_i,
	output wire s_axi_arready_o,
	output reg [31:0] s_axi_rdata_o,
	output reg [1:0] s_axi_rresp_o,
	output reg s_axi_rvalid_o,
	input wire s_axi_rready_i,
	// stream input
	input wire [DATA_W-1:0] s_axis_tdata_i,
	input wire s_axis_tvalid_i,
	input wire s_axis_tuser_i,
	input wire s_axis_tlast_i,
	output wire s_axis_tready_o,
	// stream output
	output reg [DATA_W-1:0] m_axis_tdata_o,
	output reg m_axis_tvalid_o,
	output reg m_axis_tuser_o,
	output reg m_axis_tlast_o,
	input wire m_axis_tready_i,
	// interrupt and event vector
	output reg irq_o,
	output reg [`VDNC_EV_W-1:0] event_source_vector_o
);

	function [31:0] vdnc_strb;
		input [31:0] old;
		input [31:0] wdat;
		input [3:0] ben;
		integer i;
		begin
			for (i = 0; i < 32; i = i + 1) begin
				vdnc_strb[i] = ben[i/8] ? wdat[i] : old[i];
			end
		end
	endfunction

	reg ctrl_r;
	reg [31:0] stat_r;
	reg [3:0] err_r;
	reg [16:0] mask_r;
	reg [31:0] fcnt_r;
	reg [31:0] lcnt_r;
	reg [31:0] pcnt_r;
	reg [12:0] sh_pix_r;
	reg [12:0] sh_lin_r;
	reg [2:0] sh_str_r;
	reg [12:0] act_pix_r;
	reg [12:0] act_lin_r;
	reg [2:0] act_str_r;
	reg [12:0] px_cnt_r;
	reg [12:0] ln_cnt_r;
	reg in_frame_r;
	reg [DATA_W-1:0] p1_r;
	reg [DATA_W-1:0] p2_r;

	// register bus handshakes; write takes address and data together
	// nothing is accepted while reset is held, so no request is lost there
	wire wr_go = s_axi_awvalid_i & s_axi_wvalid_i & ~s_axi_bvalid_o &
		rst_n_i;
	wire rd_go = s_axi_arvalid_i & ~s_axi_rvalid_o & rst_n_i;
	assign s_axi_awready_o = wr_go;
	assign s_axi_wready_o = wr_go;
	assign s_axi_arready_o = rd_go;
	wire [11:0] wa = {s_axi_awaddr_i[11:2], 2'b00};
	wire [11:0] ra = {s_axi_araddr_i[11:2], 2'b00};
	wire [31:0] wd = s_axi_wdata_i;
	wire [3:0] be = s_axi_wstrb_i;
	wire wr_ctrl = wr_go & (wa == `VDNC_OFS_CTRL);
	wire wr_stat = wr_go & (wa == `VDNC_OFS_STAT);
	wire wr_err = wr_go & (wa == `VDNC_OFS_ERR);
	wire wr_mask = wr_go & (wa == `VDNC_OFS_MASK);
	wire wr_size = wr_go & (wa == `VDNC_OFS_SIZE);
	wire wr_str = wr_go & (wa == `VDNC_OFS_STR);
	wire wr_ro = wr_go & ((wa == `VDNC_OFS_REV) | (wa == `VDNC_OFS_FCNT) |
		(wa == `VDNC_OFS_LCNT) | (wa == `VDNC_OFS_PCNT));
	wire wr_hit = wr_ctrl | wr_stat | wr_err | wr_mask | wr_size | wr_str |
		wr_ro;
	wire [31:0] clr_st = wr_stat ? (vdnc_strb(32'h0, wd, be) &
		`VDNC_ST_MASK) : 32'h0;
	wire [31:0] clr_er = wr_err ? (vdnc_strb(32'h0, wd, be) &
		`VDNC_ERR_MASK) : 32'h0;
	wire [31:0] mask_nxt = vdnc_strb({15'h0, mask_r}, wd, be) &
		`VDNC_MASK_BITS;

	// stream handshake: single output stage, stall propagates upstream
	wire s_rdy = ~m_axis_tvalid_o | m_axis_tready_i;
	assign s_axis_tready_o = s_rdy;
	wire beat = s_axis_tvalid_i & s_rdy;
	wire sof = beat & s_axis_tuser_i;
	wire eol = beat & s_axis_tlast_i;

	// framing checks run on the active copy of the frame size
	// a start-of-frame beat restarts both counts, so a cut frame leaves
	// no stale position behind
	wire [12:0] px_base = sof ? 13'd0 : px_cnt_r;
	wire [12:0] px_next = px_base + 13'd1;
	wire [12:0] ln_base = sof ? 13'd0 : ln_cnt_r;
	wire [12:0] ln_next = ln_base + 13'd1;
	wire frame_full = in_frame_r & (ln_cnt_r >= act_lin_r);
	wire line_end_premature = eol & (px_next < act_pix_r);
	wire line_end_overdue = beat & ~s_axis_tlast_i & (px_base >= act_pix_r);
	wire sof_early = sof & in_frame_r & ~frame_full;
	wire sof_late = beat & ~s_axis_tuser_i & frame_full;
	wire [3:0] err_ev = {sof_late, sof_early, line_end_overdue, line_end_premature};
	wire any_err = |err_ev;
	wire pix_tc = beat & (px_next == act_pix_r);
	wire frm_done = eol & in_frame_r & (ln_next == act_lin_r);
	wire ln_tc = frm_done;

	// smoothing datapath
	reg [DATA_W+1:0] sum4;
	reg [DATA_W-1:0] edge_mag;
	reg [3:0] gain;
	reg signed [DATA_W+2:0] diff;
	reg signed [DATA_W+6:0] prod;
	reg signed [DATA_W+6:0] res;
	reg [DATA_W-1:0] e1;
	reg [DATA_W-1:0] e2;
	wire [DATA_W-1:0] c = s_axis_tdata_i;
	always @* begin
		// a new line restarts the taps so pixels never mix across lines
		e1 = (px_base == 13'd0) ? c : p1_r;
		e2 = (px_base == 13'd0) ? c : ((px_base == 13'd1) ? p1_r : p2_r);
		// weights sum to four so the smoothed value stays in range
		case (act_str_r)
			3'd1: sum4 = {2'b00, c} + {1'b0, c, 1'b0} + {2'b00, e1};
			3'd2: sum4 = {1'b0, c, 1'b0} + {1'b0, e1, 1'b0};
			3'd3: sum4 = {1'b0, c, 1'b0} + {2'b00, e1} + {2'b00, e2};
			3'd4: sum4 = {2'b00, c} + {1'b0, e1, 1'b0} + {2'b00, e2};
			default: sum4 = {c, 2'b00};
		endcase
		edge_mag = (c > e1) ? (c - e1) : (e1 - c);
		// strong local contrast keeps edges sharp
		if (act_str_r == 3'd0 || act_str_r > 3'd4) begin
			gain = 4'd0;
		end else if (edge_mag > `VDNC_EDGE_HI) begin
			gain = 4'd0;
		end else if (edge_mag > `VDNC_EDGE_LO) begin
			gain = 4'd2;
		end else begin
			gain = 4'd4;
		end
		diff = $signed({1'b0, sum4}) - $signed({1'b0, c, 2'b00});
		prod = {{4{diff[DATA_W+2]}}, diff} * $signed({3'b000, gain});
		res = $signed({3'b000, c, 4'h0}) + prod;
	end

	// stream registers
	// data is registered; only the ready handshake stays combinational
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			m_axis_tdata_o <= {DATA_W{1'b0}};
			m_axis_tvalid_o <= 1'b0;
			m_axis_tuser_o <= 1'b0;
			m_axis_tlast_o <= 1'b0;
			p1_r <= {DATA_W{1'b0}};
			p2_r <= {DATA_W{1'b0}};
		end else begin
			if (s_rdy) begin
				m_axis_tvalid_o <= s_axis_tvalid_i;
				m_axis_tuser_o <= s_axis_tuser_i;
				m_axis_tlast_o <= s_axis_tlast_i;
				m_axis_tdata_o <= res[DATA_W+3:4];
			end
			if (beat) begin
				p1_r <= c;
				p2_r <= e1;
			end
		end
	end

	// frame position tracking, independent of register accesses
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			px_cnt_r <= 13'd0;
			ln_cnt_r <= 13'd0;
			in_frame_r <= 1'b0;
		end else if (beat) begin
			if (sof) begin
				in_frame_r <= 1'b1;
			end
			px_cnt_r <= s_axis_tlast_i ? 13'd0 : px_next;
			if (s_axis_tlast_i) begin
				ln_cnt_r <= frame_full ? ln_base : ln_next;
			end else begin
				ln_cnt_r <= ln_base;
			end
		end
	end

	// event vector follows the event, no latching
	// each bit trails its beat by one cycle and lasts one cycle
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			event_source_vector_o <= {`VDNC_EV_W{1'b0}};
		end else begin
			event_source_vector_o <= {err_ev, any_err, ln_tc, pix_tc,
				frm_done, sof};
		end
	end

	// throughput monitors
	// they wrap silently after 2^32 events
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			fcnt_r <= 32'h0;
			lcnt_r <= 32'h0;
			pcnt_r <= 32'h0;
		end else begin
			if (frm_done) begin
				fcnt_r <= fcnt_r + 32'h1;
			end
			if (eol) begin
				lcnt_r <= lcnt_r + 32'h1;
			end
			if (beat) begin
				pcnt_r <= pcnt_r + 32'h1;
			end
		end
	end

	// control, shadow and active configuration
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			ctrl_r <= 1'b0;
			mask_r <= 17'h0;
			sh_pix_r <= DEF_PIX;
			sh_lin_r <= DEF_LIN;
			sh_str_r <= DEF_STR;
			act_pix_r <= DEF_PIX;
			act_lin_r <= DEF_LIN;
			act_str_r <= DEF_STR;
		end else begin
			if (wr_ctrl && be[0]) begin
				ctrl_r <= wd[`VDNC_CTRL_COMMIT];
			end
			if (wr_mask) begin
				mask_r <= mask_nxt[16:0];
			end
			if (wr_size) begin
				if (be[0]) begin
					sh_pix_r[7:0] <= wd[7:0];
				end
				if (be[1]) begin
					sh_pix_r[12:8] <= wd[`VDNC_SZ_PIX_HI:8];
				end
				if (be[2]) begin
					sh_lin_r[7:0] <= wd[23:`VDNC_SZ_LIN_LO];
				end
				if (be[3]) begin
					sh_lin_r[12:8] <= wd[`VDNC_SZ_LIN_HI:24];
				end
			end
			if (wr_str && be[0]) begin
				sh_str_r <= wd[2:0];
			end
			// commit only at a frame boundary to avoid tearing
			// commit is not self-clearing: while it stays set, every frame
			// end reloads the active copies from the shadows
			if (frm_done && ctrl_r) begin
				act_pix_r <= sh_pix_r;
				act_lin_r <= sh_lin_r;
				act_str_r <= sh_str_r;
			end
		end
	end

	// sticky flags: a new event wins over a clear in the same cycle
	// bit 16 sums up the error flags but is cleared on its own
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			stat_r <= 32'h0;
			err_r <= 4'h0;
		end else begin
			err_r <= (err_r & ~clr_er[3:0]) | err_ev;
			stat_r[`VDNC_ST_BEGUN] <= (stat_r[`VDNC_ST_BEGUN] &
				~clr_st[`VDNC_ST_BEGUN]) | sof;
			stat_r[`VDNC_ST_DONE] <= (stat_r[`VDNC_ST_DONE] &
				~clr_st[`VDNC_ST_DONE]) | frm_done;
			stat_r[`VDNC_ST_SLVERR] <= (stat_r[`VDNC_ST_SLVERR] &
				~clr_st[`VDNC_ST_SLVERR]) | any_err;
		end
	end

	// level interrupt from enabled status flags
	// one cycle behind the flags, so a clear drops the line a cycle later
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(stat_r[16:0] & mask_r);
		end
	end

	// write response
	// unmapped writes are answered with an error and change nothing
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= `VDNC_RESP_OK;
		end else if (wr_go) begin
			s_axi_bvalid_o <= 1'b1;
			s_axi_bresp_o <= wr_hit ? `VDNC_RESP_OK : `VDNC_RESP_SLVERR;
		end else if (s_axi_bready_i) begin
			s_axi_bvalid_o <= 1'b0;
		end
	end

	// read data
	// size and strength read back the shadows, not what the filter uses
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h0;
			s_axi_rresp_o <= `VDNC_RESP_OK;
		end else if (rd_go) begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rresp_o <= `VDNC_RESP_OK;
			case (ra)
				`VDNC_OFS_CTRL: s_axi_rdata_o <= {30'h0, ctrl_r, 1'b0};
				`VDNC_OFS_STAT: s_axi_rdata_o <= stat_r;
				`VDNC_OFS_ERR: s_axi_rdata_o <= {28'h0, err_r};
				`VDNC_OFS_MASK: s_axi_rdata_o <= {15'h0, mask_r};
				`VDNC_OFS_REV: s_axi_rdata_o <= REV_VALUE;
				`VDNC_OFS_FCNT: s_axi_rdata_o <= fcnt_r;
				`VDNC_OFS_LCNT: s_axi_rdata_o <= lcnt_r;
				`VDNC_OFS_PCNT: s_axi_rdata_o <= pcnt_r;
				`VDNC_OFS_SIZE: s_axi_rdata_o <= {3'h0, sh_lin_r, 3'h0, sh_pix_r};
				`VDNC_OFS_STR: s_axi_rdata_o <= {29'h0, sh_str_r};
				default: begin
					s_axi_rdata_o <= 32'h0;
					s_axi_rresp_o <= `VDNC_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end

endmodule // vdnc_top
`default_nettype wire

// *** core/vdnc_consts.vh ***
// Purpose: constants of the video smoothing control/status block
// Assumes: 32-bit register bus, byte addresses as printed
// Notes: included by vdnc_top.v and by the testbench
`ifndef VDNC_CONSTS_VH
`define VDNC_CONSTS_VH
`define VDNC_OFS_CTRL 12'h000
`define VDNC_OFS_STAT 12'h004
`define VDNC_OFS_ERR 12'h008
`define VDNC_OFS_MASK 12'h00c
`define VDNC_OFS_REV 12'h010
`define VDNC_OFS_FCNT 12'h014
`define VDNC_OFS_LCNT 12'h018
`define VDNC_OFS_PCNT 12'h01c
`define VDNC_OFS_SIZE 12'h020
`define VDNC_OFS_STR 12'h100
`define VDNC_CTRL_COMMIT 1
`define VDNC_ST_BEGUN 0
`define VDNC_ST_DONE 1
`define VDNC_ST_SLVERR 16
`define VDNC_ST_MASK 32'h0001_0003
`define VDNC_MASK_BITS 32'h0001_ffff
`define VDNC_ERR_MASK 32'h0000_000f
`define VDNC_SZ_PIX_HI 12
`define VDNC_SZ_LIN_LO 16
`define VDNC_SZ_LIN_HI 28
`define VDNC_EV_W 9
`define VDNC_RESP_OK 2'b00
`define VDNC_RESP_SLVERR 2'b10
`define VDNC_EDGE_LO 8'h10
`define VDNC_EDGE_HI 8'h30
`endif

// *** verification/vdnc_chk.sv ***
// Purpose: port-level checks of vdnc_top
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every vdnc_top instance
`timescale 1ns/100ps
`default_nettype none
module vdnc_chk (
	// clock and reset
	input wire clk_i,
	input wire rst_n_i,
	// register bus
	input wire s_axi_awvalid_i,
	input wire s_axi_wvalid_i,
	input wire s_axi_awready_o,
	input wire s_axi_bvalid_o,
	input wire [1:0] s_axi_bresp_o,
	input wire s_axi_bready_i,
	input wire s_axi_arvalid_i,
	input wire s_axi_arready_o,
	input wire s_axi_rvalid_o,
	input wire [31:0] s_axi_rdata_o,
	input wire s_axi_rready_i,
	// stream and events
	input wire s_axis_tvalid_i,
	input wire s_axis_tuser_i,
	input wire s_axis_tlast_i,
	input wire s_axis_tready_o,
	input wire m_axis_tvalid_o,
	input wire m_axis_tuser_o,
	input wire m_axis_tlast_o,
	input wire m_axis_tready_i,
	input wire [8:0] event_source_vector_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_in; s_axis_tvalid_i && s_axis_tready_o; endsequence
	sequence s_sof; s_in ##0 s_axis_tuser_i; endsequence
	property p_pass; s_in |=> m_axis_tvalid_o
		&& m_axis_tuser_o == $past(s_axis_tuser_i)
		&& m_axis_tlast_o == $past(s_axis_tlast_i); endproperty
	property p_stall; m_axis_tvalid_o && !m_axis_tready_i |=> m_axis_tvalid_o
		&& $stable({m_axis_tuser_o, m_axis_tlast_o}); endproperty
	property p_rdy; s_axis_tready_o == (!m_axis_tvalid_o || m_axis_tready_i);
	endproperty
	property p_sof; s_sof |=> event_source_vector_o[0]; endproperty
	property p_pulse; event_source_vector_o[0] |->
		$past(s_axis_tvalid_i && s_axis_tready_o && s_axis_tuser_i); endproperty
	property p_err; event_source_vector_o[4] == (|event_source_vector_o[8:5]);
	endproperty
	property p_wr; s_axi_awvalid_i && s_axi_wvalid_i && s_axi_awready_o
		|=> s_axi_bvalid_o; endproperty
	property p_bh; s_axi_bvalid_o && !s_axi_bready_i
		|=> s_axi_bvalid_o && $stable(s_axi_bresp_o); endproperty
	property p_rd; s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
	endproperty
	property p_rh; s_axi_rvalid_o && !s_axi_rready_i
		|=> s_axi_rvalid_o && $stable(s_axi_rdata_o); endproperty
	a_pass: assert property (p_pass) else $error("beat lost");
	a_stall: assert property (p_stall) else $error("beat dropped");
	a_rdy: assert property (p_rdy) else $error("bad tready");
	a_sof: assert property (p_sof) else $error("no start event");
	a_pulse: assert property (p_pulse) else $error("event held");
	a_err: assert property (p_err) else $error("bad error event");
	a_wr: assert property (p_wr) else $error("no write answer");
	a_bh: assert property (p_bh) else $error("write answer dropped");
	a_rd: assert property (p_rd) else $error("no read answer");
	a_rh: assert property (p_rh) else $error("read answer dropped");
endmodule // vdnc_chk
bind vdnc_top vdnc_chk chk_u (.clk_i, .rst_n_i, .s_axi_awvalid_i,
	.s_axi_wvalid_i, .s_axi_awready_o, .s_axi_bvalid_o, .s_axi_bresp_o,
	.s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o,
	.s_axi_rdata_o, .s_axi_rready_i, .s_axis_tvalid_i, .s_axis_tuser_i,
	.s_axis_tlast_i, .s_axis_tready_o, .m_axis_tvalid_o, .m_axis_tuser_o,
	.m_axis_tlast_o, .m_axis_tready_i, .event_source_vector_o);
`default_nettype wire

// *** verification/vdnc_sink.sv ***
// Purpose: downstream stream sink that tallies beats and lines
// Assumes: same clock and reset as the block
// Notes: slow mode drops ready every other cycle
`timescale 1ns/100ps
`default_nettype none
module vdnc_sink (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// stream from block
	input wire logic tvalid_i,
	input wire logic tlast_i,
	output logic tready_o,
	// control and tallies
	input wire logic slow_i,
	output logic [15:0] beats_o,
	output logic [15:0] lines_o
);
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			tready_o <= 1'b0;
			beats_o <= 16'h0;
			lines_o <= 16'h0;
		end else begin
			// stalls force the block to hold its output beat
			tready_o <= slow_i ? ~tready_o : 1'b1;
			if (tvalid_i && tready_o) begin
				beats_o <= beats_o + 16'h1;
				lines_o <= lines_o + {15'h0, tlast_i};
			end
		end
	end
endmodule // vdnc_sink
`default_nettype wire

// *** verification/testbench.sv ***
// Purpose: self-checking bench of vdnc_top
// Assumes: frame of 4 pixels by 2 lines set by parameters
// Notes: output beats are tallied by vdnc_sink
`timescale 1ns/100ps
`default_nettype none
`include "vdnc_consts.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
	n_mismatch++; \
	$display("CHECK FAILED %0t value mismatch %h %h", $time, a, b); end end
module testbench;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [11:0] s_axi_awaddr_i = '0;
	logic [11:0] s_axi_araddr_i = '0;
	logic [31:0] s_axi_wdata_i = '0;
	logic [3:0] s_axi_wstrb_i = 4'hf;
	logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
	logic s_axi_arvalid_i = 0, s_axi_rready_i = 0, sl = 0;
	logic [7:0] s_axis_tdata_i = '0;
	logic s_axis_tvalid_i = 0, s_axis_tuser_i = 0, s_axis_tlast_i = 0;
	wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
	wire s_axi_rvalid_o, s_axis_tready_o, m_axis_tvalid_o, m_axis_tuser_o;
	wire m_axis_tlast_o, m_axis_tready_i, irq_o;
	wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
	wire [31:0] s_axi_rdata_o;
	wire [7:0] m_axis_tdata_o;
	wire [8:0] event_source_vector_o;
	wire [15:0] nb, nl;
	logic [31:0] v;
	logic [7:0] step = 8'h10;
	logic [7:0] cap [0:255];
	int n_mismatch = 0, num_checks = 0;
	always #25 clk_i = ~clk_i;
	vdnc_top #(.DEF_PIX(13'd4), .DEF_LIN(13'd2)) dut_u (.clk_i, .rst_n_i,
		.s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
		.s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
		.s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
		.s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
		.s_axi_rready_i, .s_axis_tdata_i, .s_axis_tvalid_i, .s_axis_tuser_i,
		.s_axis_tlast_i, .s_axis_tready_o, .m_axis_tdata_o, .m_axis_tvalid_o,
		.m_axis_tuser_o, .m_axis_tlast_o, .m_axis_tready_i, .irq_o,
		.event_source_vector_o);
	vdnc_sink sink_u (.clk_i, .rst_n_i, .tvalid_i(m_axis_tvalid_o),
		.tlast_i(m_axis_tlast_o), .tready_o(m_axis_tready_i), .slow_i(sl),
		.beats_o(nb), .lines_o(nl));
	// output pixels indexed by the sink's beat tally
	always @(posedge clk_i)
		if (m_axis_tvalid_o && m_axis_tready_i)
			cap[nb[7:0]] <= m_axis_tdata_o;
	task automatic wr(input [11:0] a, input [31:0] d, input [1:0] e);
		@(posedge clk_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		do @(posedge clk_i); while (s_axi_awready_o !== 1'b1);
		`CHK(s_axi_wready_o, 1'b1)
		s_axi_awvalid_i <= 1'b0;
		s_axi_wvalid_i <= 1'b0;
		do @(posedge clk_i); while (s_axi_bvalid_o !== 1'b1);
		s_axi_bready_i <= 1'b1;
		@(posedge clk_i);
		`CHK(s_axi_bresp_o, e)
		s_axi_bready_i <= 1'b0;
	endtask
	task automatic rc(input [11:0] a, input [31:0] x, input [1:0] e);
		@(posedge clk_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		do @(posedge clk_i); while (s_axi_arready_o !== 1'b1);
		s_axi_arvalid_i <= 1'b0;
		do @(posedge clk_i); while (s_axi_rvalid_o !== 1'b1);
		s_axi_rready_i <= 1'b1;
		@(posedge clk_i);
		v = s_axi_rdata_o;
		`CHK(s_axi_rresp_o, e)
		if (e == 2'b00 || x == 32'h0) `CHK(v, x)
		s_axi_rready_i <= 1'b0;
	endtask
	task automatic line(input int n, input bit u);
		@(posedge clk_i);
		for (int i = 0; i < n; i++) begin
			s_axis_tdata_i <= 8'(i * step);
			s_axis_tvalid_i <= 1'b1;
			s_axis_tuser_i <= u && (i == 0);
			s_axis_tlast_i <= (i == n - 1);
			do @(posedge clk_i); while (s_axis_tready_o !== 1'b1);
		end
		s_axis_tvalid_i <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask
	task t_basic;
		rc(`VDNC_OFS_REV, 32'h0100_0000, 2'b00);
		wr(`VDNC_OFS_REV, 32'hffff_ffff, 2'b00);
		rc(`VDNC_OFS_REV, 32'h0100_0000, 2'b00);
		rc(`VDNC_OFS_FCNT, 32'h0, 2'b00);
		rc(12'h200, 32'h0, 2'b10);
		wr(12'h200, 32'h0, 2'b10);
	endtask
	task t_frame;
		sl <= 1'b1;
		line(4, 1'b1);
		line(4, 1'b0);
		sl <= 1'b0;
		`CHK(nb, 16'd8)
		`CHK(nl, 16'd2)
		rc(`VDNC_OFS_STAT, 32'h3, 2'b00);
		rc(`VDNC_OFS_ERR, 32'h0, 2'b00);
		rc(`VDNC_OFS_FCNT, 32'h1, 2'b00);
		rc(`VDNC_OFS_LCNT, 32'h2, 2'b00);
		rc(`VDNC_OFS_PCNT, 32'h8, 2'b00);
		wr(`VDNC_OFS_STAT, 32'h3, 2'b00);
	endtask
	task t_lerr;
		line(3, 1'b1);
		rc(`VDNC_OFS_ERR, 32'h1, 2'b00);
		rc(`VDNC_OFS_STAT, 32'h1_0001, 2'b00);
		line(6, 1'b0);
		rc(`VDNC_OFS_ERR, 32'h3, 2'b00);
		wr(`VDNC_OFS_ERR, 32'h1, 2'b00);
		rc(`VDNC_OFS_ERR, 32'h2, 2'b00);
		wr(`VDNC_OFS_MASK, 32'h1_0000, 2'b00);
		repeat (10) @(posedge clk_i);
		`CHK(irq_o, 1'b1)
		wr(`VDNC_OFS_MASK, 32'h0, 2'b00);
		repeat (2) @(posedge clk_i);
		`CHK(irq_o, 1'b0)
		wr(`VDNC_OFS_MASK, 32'h1_0000, 2'b00);
		wr(`VDNC_OFS_STAT, 32'h1_0000, 2'b00);
		repeat (2) @(posedge clk_i);
		`CHK(irq_o, 1'b0)
	endtask
	task t_ferr;
		wr(`VDNC_OFS_ERR, 32'hf, 2'b00);
		line(4, 1'b1);
		line(4, 1'b1);
		line(4, 1'b0);
		line(4, 1'b0);
		rc(`VDNC_OFS_ERR, 32'hc, 2'b00);
		`CHK(v[3:2], 2'b11)
	endtask
	task t_filt;
		logic [7:0] base;
		wr(`VDNC_OFS_STR, 32'h0, 2'b00);
		wr(`VDNC_OFS_CTRL, 32'h2, 2'b00);
		rc(`VDNC_OFS_CTRL, 32'h2, 2'b00);
		line(4, 1'b1);
		line(4, 1'b0);
		wr(`VDNC_OFS_STR, 32'h4, 2'b00);
		base = nb[7:0];
		line(4, 1'b1);
		for (int i = 0; i < 4; i++)
			`CHK(cap[8'(base + i)], 8'(i * 16))
		line(4, 1'b0);
		step = 8'h40;
		base = nb[7:0];
		line(4, 1'b1);
		for (int i = 0; i < 4; i++)
			`CHK(cap[8'(base + i)], 8'(i * 64))
		step = 8'h08;
		base = nb[7:0];
		line(4, 1'b0);
		`CHK(cap[8'(base + 3)] < 8'h18, 1'b1)
	endtask
	task t_regs;
		wr(`VDNC_OFS_SIZE, 32'h0020_0040, 2'b00);
		rc(`VDNC_OFS_SIZE, 32'h0020_0040, 2'b00);
		for (int s = 0; s < 5; s++) begin
			wr(`VDNC_OFS_STR, 32'(s), 2'b00);
			rc(`VDNC_OFS_STR, 32'(s), 2'b00);
		end
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rc(`VDNC_OFS_PCNT, 32'h0, 2'b00);
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_basic;
		t_frame;
		t_lerr;
		t_ferr;
		t_filt;
		t_regs;
		print_verdict;
	end
	// about 20000 cycles, far beyond the few hundred the tests need
	initial begin
		#1000000;
		n_mismatch++;
		print_verdict;
	end
endmodule // testbench
`default_nettype wire
